/* File: acg_clock_gen.sv */
// clock source, pll ratio, scaler and interface framing control
`timescale 1ns/1ps
module acg_clock_gen (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // register port
    input wire acg_pkg::acg_bus_t bus,
    output logic [8:0] rdata,
    // external pins
    input wire logic mclk_pin,
    input wire logic bclk_in,
    output acg_pkg::acg_pin_t bclk_pin,
    input wire logic frame_in,
    output acg_pkg::acg_pin_t frame_pin,
    input wire logic play_pin,
    // data from the serial engines
    input wire logic rec_tx_data,
    input wire logic play_tx_data,
    input wire logic adc_data,
    // data and timing to the core
    output logic play_data,
    output logic rec_data,
    output logic play_slot,
    output logic rec_slot,
    output logic core_tick,
    output logic fs_tick,
    output logic [2:0] filt_sel,
    output logic pll_on,
    output logic [3:0] pll_integer_ratio,
    output logic [23:0] pll_fraction_ratio
);
    import acg_pkg::*;

    typedef struct packed {
        logic [ACG_NREG-1:0][8:0] regs;
        logic [8:0] rdata;
        logic mclk_prev;
        logic [1:0] pre_cnt;
        logic [29:0] pll_acc;
        logic pll_tick;
        logic pll_on;
        logic src_tick;
        logic [4:0] bclk_cnt;
        logic bclk_o;
        logic frame_o;
        logic [5:0] bit_cnt;
        logic [7:0] fs_cnt;
        logic fs_tick;
        logic play_data;
        logic rec_data;
        logic play_slot;
        logic rec_slot;
        logic [2:0] filt_sel;
        logic ms;
    } acg_st_t;

    acg_st_t st_q, st_d;
    logic [3:0] pin_s;
    logic mclk_s, bclk_s, frame_s, play_s;
    logic scl_tick;
    logic [8:0] r_pwr, r_aif, r_comp, r_clk, r_add, r_pll_integer_ratio;
    logic pll_enable, pll_power_off, fractional_enable;
    logic [1:0] reference_voltage_select, pll_input_prescale;
    logic playback_phase_swap, record_phase_swap;
    logic byte_length_enable, master_mode_select, core_source_select;
    logic playback_loop, record_loop;
    logic [1:0] word_length_field, fmt_sel;
    logic [2:0] clock_scaler, bit_clock_divider, sample_rate_select;
    logic [5:0] wl_eff;
    logic [27:0] pll_step;
    logic [29:0] pll_sum;
    logic mclk_rise, mclk_fall, ref_tick, phase;
    logic [8:0] rsel;

    // pins from outside the clock domain
    acg_sync #(.W(4)) u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .din({play_pin, frame_in, bclk_in, mclk_pin}),
        .dout(pin_s)
    );
    assign mclk_s = pin_s[0];
    assign bclk_s = pin_s[1];
    assign frame_s = pin_s[2];
    assign play_s = pin_s[3];

    // fields decoded from the register file
    assign r_pwr = st_q.regs[ACG_S_PWR1];
    assign r_aif = st_q.regs[ACG_S_AIF];
    assign r_comp = st_q.regs[ACG_S_COMP];
    assign r_clk = st_q.regs[ACG_S_CLK];
    assign r_add = st_q.regs[ACG_S_ADD];
    assign r_pll_integer_ratio = st_q.regs[ACG_S_PLL_INTEGER_RATIO];
    assign pll_enable = r_pwr[ACG_B_PLL_ENABLE];
    assign reference_voltage_select = r_pwr[ACG_B_VREF +: 2];
    assign playback_phase_swap = r_aif[ACG_B_PSWAP];
    assign record_phase_swap = r_aif[ACG_B_RSWAP];
    assign word_length_field = r_aif[ACG_B_WL +: 2];
    assign fmt_sel = r_aif[ACG_B_FMT +: 2];
    assign byte_length_enable = r_comp[ACG_B_BYTELEN];
    assign playback_loop = r_comp[ACG_B_PLOOP];
    assign record_loop = r_comp[ACG_B_RLOOP];
    assign core_source_select = r_clk[ACG_B_SRC];
    assign clock_scaler = r_clk[ACG_B_SCALE +: 3];
    assign bit_clock_divider = r_clk[ACG_B_BDIV +: 3];
    assign master_mode_select = r_clk[ACG_B_MS];
    assign sample_rate_select = r_add[ACG_B_SR +: 3];
    assign pll_power_off = r_pll_integer_ratio[ACG_B_PWROFF];
    assign fractional_enable = r_pll_integer_ratio[ACG_B_FRAC];
    assign pll_input_prescale = r_pll_integer_ratio[ACG_B_PRE +: 2];

    // effective word length per frame half
    always_comb begin
        if (byte_length_enable) begin
            wl_eff = ACG_WL_BYTE;
        end else if (fmt_sel == ACG_FMT_RJ && word_length_field == 2'h3) begin
            wl_eff = ACG_WL_RJMAX;
        end else begin
            wl_eff = ACG_WL_BITS[word_length_field];
        end
    end

    // reference conditioning ahead of the pll
    assign mclk_rise = mclk_s & ~st_q.mclk_prev;
    assign mclk_fall = ~mclk_s & st_q.mclk_prev;
    always_comb begin
        case (pll_input_prescale)
            2'h0: ref_tick = mclk_rise | mclk_fall;
            2'h1: ref_tick = mclk_rise;
            2'h2: ref_tick = mclk_rise & st_q.pre_cnt[0];
            default: ref_tick = mclk_rise & (st_q.pre_cnt == 2'h3);
        endcase
    end

    // ratio step: integer plus fraction in units of 2^-24
    always_comb begin
        pll_step = {pll_integer_ratio, 24'h00_0000};
        if (fractional_enable) begin
            pll_step = {pll_integer_ratio, pll_fraction_ratio};
        end
        pll_sum = st_q.pll_acc;
        if (ref_tick && st_q.pll_acc < ACG_PLL_CAP) begin
            pll_sum = st_q.pll_acc + {2'h0, pll_step};
        end
    end

    // read mux; unmapped words read zero
    always_comb begin
        rsel = 9'h000;
        for (int i = 0; i < ACG_NREG; i++) begin
            if (bus.addr[7:2] == ACG_REG_IDX[i]) begin
                rsel = st_q.regs[i];
            end
        end
        if (bus.addr[7:2] == ACG_IDX_STAT) begin
            rsel = {4'h0, st_q.rec_slot, st_q.play_slot, phase,
                core_source_select, st_q.pll_on};
        end
    end

    assign phase = master_mode_select ? st_q.frame_o : frame_s;

    // next state of the whole block
    always_comb begin
        st_d = st_q;
        // register writes and one-cycle read data
        st_d.rdata = 9'h000;
        if (bus.rd) begin
            st_d.rdata = rsel;
        end
        for (int i = 0; i < ACG_NREG; i++) begin
            if (bus.wr && bus.addr[7:2] == ACG_REG_IDX[i] && bus.addr[1:0] == 2'h0) begin
                st_d.regs[i] = bus.wdata;
            end
        end
        // pll gating: enable, reference voltage and power-down
        st_d.pll_on = pll_enable
            && reference_voltage_select != ACG_VREF_OFF
            && !pll_power_off;
        st_d.mclk_prev = mclk_s;
        if (mclk_rise) begin
            st_d.pre_cnt = st_q.pre_cnt + 2'h1;
        end
        // fixed divide by four: one tick per four output cycles of credit
        st_d.pll_tick = 1'b0;
        if (!st_q.pll_on) begin
            st_d.pll_acc = 30'h0000_0000;
        end else if (pll_sum >= ACG_PLL_ONE) begin
            st_d.pll_acc = pll_sum - ACG_PLL_ONE;
            st_d.pll_tick = 1'b1;
        end else begin
            st_d.pll_acc = pll_sum;
        end
        // source select ahead of the scaler
        st_d.src_tick = core_source_select ? st_q.pll_tick : mclk_rise;
        // master bit and frame clocks from the core clock
        st_d.ms = master_mode_select;
        if (!master_mode_select) begin
            st_d.bclk_o = 1'b0;
            st_d.frame_o = 1'b0;
            st_d.bclk_cnt = 5'h00;
            st_d.bit_cnt = 6'h00;
        end else if (scl_tick) begin
            if (st_q.bclk_cnt >= ACG_BDIV_HALF[bit_clock_divider]) begin
                st_d.bclk_cnt = 5'h00;
                st_d.bclk_o = ~st_q.bclk_o;
                if (st_q.bclk_o) begin
                    if (st_q.bit_cnt >= wl_eff - 6'h01) begin
                        st_d.bit_cnt = 6'h00;
                        st_d.frame_o = ~st_q.frame_o;
                    end else begin
                        st_d.bit_cnt = st_q.bit_cnt + 6'h01;
                    end
                end
            end else begin
                st_d.bclk_cnt = st_q.bclk_cnt + 5'h01;
            end
        end
        // frame half that each direction occupies
        st_d.play_slot = (phase == playback_phase_swap);
        st_d.rec_slot = (phase == record_phase_swap);
        // digital loopback
        st_d.play_data = record_loop ? rec_tx_data : play_s;
        st_d.rec_data = playback_loop ? play_tx_data : adc_data;
        // filter rate and 256 core ticks per sample
        st_d.filt_sel = (sample_rate_select > ACG_SR_MAX) ? ACG_SR_MAX
            : sample_rate_select;
        st_d.fs_tick = 1'b0;
        if (scl_tick) begin
            st_d.fs_cnt = st_q.fs_cnt + 8'h01;
            st_d.fs_tick = (st_q.fs_cnt == ACG_FS_LAST);
        end
    end

    // divider to core clock after the source mux
    acg_scaler u_scaler (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .code(clock_scaler),
        .tick_in(st_q.src_tick),
        .tick_out(scl_tick)
    );

    // state register; clock enable freezes everything
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.regs <= ACG_REG_RST;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops
    assign rdata = st_q.rdata;
    assign bclk_pin = '{o: st_q.bclk_o, oe: st_q.ms};
    assign frame_pin = '{o: st_q.frame_o, oe: st_q.ms};
    assign play_data = st_q.play_data;
    assign rec_data = st_q.rec_data;
    assign play_slot = st_q.play_slot;
    assign rec_slot = st_q.rec_slot;
    assign core_tick = scl_tick;
    assign fs_tick = st_q.fs_tick;
    assign filt_sel = st_q.filt_sel;
    assign pll_on = st_q.pll_on;
    assign pll_integer_ratio = r_pll_integer_ratio[ACG_B_N +: 4];
    assign pll_fraction_ratio = {st_q.regs[ACG_S_K1][5:0],
        st_q.regs[ACG_S_K2], st_q.regs[ACG_S_K3]};

    // checks
    AST_VREF_OFF: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && reference_voltage_select == ACG_VREF_OFF |=> !st_q.pll_on)
        else $error("pll on with reference voltage off");
    AST_PLL_EN: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && !pll_enable |=> !st_q.pll_on)
        else $error("pll on while disabled");
    AST_PWR_OFF: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && pll_power_off |=> !st_q.pll_on)
        else $error("pll on while powered down");
    AST_PLL_QUIET: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && !st_q.pll_on |=> !st_q.pll_tick && st_q.pll_acc == 30'h0000_0000)
        else $error("pll ticks while off");
    AST_SRC_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && !core_source_select && !mclk_rise |=> !st_q.src_tick)
        else $error("source tick without master clock edge");
    AST_SLAVE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && !master_mode_select |=> !bclk_pin.oe && !frame_pin.oe && !bclk_pin.o)
        else $error("clock pins driven in slave mode");
    // reset_n in the antecedent skips the release edge, where the flops still load reset
    AST_PSLOT: assert property (@(posedge sys_clk) disable iff (!reset_n)
        reset_n && clk_en |=> play_slot == ($past(phase) == $past(playback_phase_swap)))
        else $error("playback slot wrong");
    AST_RSLOT: assert property (@(posedge sys_clk) disable iff (!reset_n)
        reset_n && clk_en |=> rec_slot == ($past(phase) == $past(record_phase_swap)))
        else $error("record slot wrong");
    AST_RLOOP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && record_loop |=> play_data == $past(rec_tx_data))
        else $error("record loopback not routed");
    AST_PLOOP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && playback_loop |=> rec_data == $past(play_tx_data))
        else $error("playback loopback not routed");
    AST_BYTE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        byte_length_enable |-> wl_eff == ACG_WL_BYTE)
        else $error("byte length not forced");
    AST_RJ: assert property (@(posedge sys_clk) disable iff (!reset_n)
        fmt_sel == ACG_FMT_RJ |-> wl_eff <= ACG_WL_RJMAX)
        else $error("right justified above 24 bits");
    AST_RATE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en |=> filt_sel <= ACG_SR_MAX)
        else $error("reserved sample rate code passed");
endmodule

/* File: acg_host_model.sv */
// reference clock and serial audio host facing the clock block
`timescale 1ns/1ps
module acg_host_model #(parameter real MCLK_HALF = 151.3, parameter int BITS = 16) (
    // host control
    input wire logic host_en,
    // pins toward the device
    output logic mclk,
    output logic bclk,
    output logic frame,
    output logic data
);
    // free-running reference, phase unrelated to the system clock
    initial begin
        mclk = 1'b0;
        forever #(MCLK_HALF) mclk = ~mclk;
    end
    // slave host drives both clocks; bclk stands still while idle
    initial begin
        bclk = 1'b0;
        frame = 1'b0;
        data = 1'b0;
        forever begin
            wait (host_en);
            repeat (BITS) begin
                #400 bclk = 1'b1;
                #400 bclk = 1'b0;
                data = ~data; // data changes every bit
            end
            frame = ~frame;
        end
    end
endmodule

/* File: acg_pkg.sv */
// shared constants and types for the audio clock generation block
package acg_pkg;
    // register slots, word indexes and power-on values
    localparam int ACG_NREG = 9;
    localparam int ACG_S_PWR1 = 0;
    localparam int ACG_S_AIF = 1;
    localparam int ACG_S_COMP = 2;
    localparam int ACG_S_CLK = 3;
    localparam int ACG_S_ADD = 4;
    localparam int ACG_S_PLL_INTEGER_RATIO = 5;
    localparam int ACG_S_K1 = 6;
    localparam int ACG_S_K2 = 7;
    localparam int ACG_S_K3 = 8;
    localparam logic [8:0][5:0] ACG_REG_IDX = {6'h27, 6'h26, 6'h25, 6'h24,
        6'h07, 6'h06, 6'h05, 6'h04, 6'h01};
    localparam logic [5:0] ACG_IDX_STAT = 6'h28;
    localparam logic [8:0][8:0] ACG_REG_RST = {9'h0E9, 9'h093, 9'h00C, 9'h04C,
        9'h000, 9'h140, 9'h000, 9'h050, 9'h000};
    // field positions
    localparam int ACG_B_VREF = 0;
    localparam int ACG_B_PLL_ENABLE = 5;
    localparam int ACG_B_RSWAP = 1;
    localparam int ACG_B_PSWAP = 2;
    localparam int ACG_B_FMT = 3;
    localparam int ACG_B_WL = 5;
    localparam int ACG_B_RLOOP = 0;
    localparam int ACG_B_BYTELEN = 5;
    localparam int ACG_B_PLOOP = 6;
    localparam int ACG_B_MS = 0;
    localparam int ACG_B_BDIV = 2;
    localparam int ACG_B_SCALE = 5;
    localparam int ACG_B_SRC = 8;
    localparam int ACG_B_SR = 1;
    localparam int ACG_B_N = 0;
    localparam int ACG_B_PRE = 4;
    localparam int ACG_B_FRAC = 6;
    localparam int ACG_B_PWROFF = 7;
    // encodings and counts
    localparam logic [1:0] ACG_FMT_RJ = 2'h0;
    localparam logic [1:0] ACG_VREF_OFF = 2'h0;
    localparam logic [3:0][5:0] ACG_WL_BITS = {6'h20, 6'h18, 6'h14, 6'h10};
    localparam logic [5:0] ACG_WL_BYTE = 6'h08;
    localparam logic [5:0] ACG_WL_RJMAX = 6'h18;
    localparam logic [7:0][4:0] ACG_SCALE_HALF = {5'h18, 5'h10, 5'h0C, 5'h08,
        5'h06, 5'h04, 5'h03, 5'h02};
    localparam logic [7:0][4:0] ACG_BDIV_HALF = {5'h1F, 5'h1F, 5'h1F, 5'h0F,
        5'h07, 5'h03, 5'h01, 5'h00};
    localparam logic [29:0] ACG_PLL_ONE = 30'h0400_0000;
    localparam logic [29:0] ACG_PLL_CAP = 30'h1000_0000;
    localparam logic [7:0] ACG_FS_LAST = 8'hFF;
    localparam logic [2:0] ACG_SR_MAX = 3'h5;
    // carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [8:0] wdata;
    } acg_bus_t;
    typedef struct packed {
        logic o;
        logic oe;
    } acg_pin_t;
endpackage

/* File: acg_scaler.sv */
// tick divider by 1, 1.5, 2, 3, 4, 6, 8 or 12
`timescale 1ns/1ps
module acg_scaler (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // ratio code and ticks
    input wire logic [2:0] code,
    input wire logic tick_in,
    output logic tick_out
);
    import acg_pkg::*;
    typedef struct packed {
        logic [4:0] acc;
        logic tick;
    } acg_scl_t;
    acg_scl_t st_q, st_d;
    logic [4:0] sum;
    // counts in half ticks so 1.5 and 3 stay exact
    always_comb begin
        st_d = st_q;
        sum = st_q.acc + 5'h02;
        st_d.tick = 1'b0;
        if (tick_in) begin
            if (sum >= ACG_SCALE_HALF[code]) begin
                st_d.acc = sum - ACG_SCALE_HALF[code];
                st_d.tick = 1'b1;
            end else begin
                st_d.acc = sum;
            end
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end
    assign tick_out = st_q.tick;
endmodule

/* File: acg_sync.sv */
// two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
module acg_sync #(parameter int W = 4) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // pins in, synchronised out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } acg_syn_t;
    acg_syn_t st_q, st_d;
    // first stage feeds only the second
    always_comb begin
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end
    assign dout = st_q.s2;
endmodule

/* File: tb.sv */
// self-checking bench for the audio clock generation block
`timescale 1ns/1ps
module tb;
    import acg_pkg::*;
    logic sys_clk, reset_n, host_en, mclk, hbclk, hframe, play_pin;
    logic rec_tx_data, play_tx_data, adc_data, bclk_q;
    acg_bus_t bus;
    logic [8:0] rdata;
    acg_pin_t bclk_pin, frame_pin;
    logic play_data, rec_data, play_slot, rec_slot, core_tick, fs_tick, pll_on;
    logic [2:0] filt_sel;
    logic [3:0] pll_integer_ratio;
    logic [23:0] pll_fraction_ratio;
    logic [31:0] seed = 32'h0000_0050;
    int mismatches, check_count, n_mclk, n_core, n_bclk, run, gap;
    int div2 [8] = '{2, 3, 4, 6, 8, 12, 16, 24};
    int wlb [4] = '{16, 20, 24, 32};
    // pin level from whichever side drives it
    wire bclk_in = bclk_pin.oe ? bclk_pin.o : hbclk;
    wire frame_in = frame_pin.oe ? frame_pin.o : hframe;

    acg_clock_gen u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1), .bus(bus),
        .rdata(rdata), .mclk_pin(mclk), .bclk_in(bclk_in), .bclk_pin(bclk_pin),
        .frame_in(frame_in), .frame_pin(frame_pin), .play_pin(play_pin),
        .rec_tx_data(rec_tx_data), .play_tx_data(play_tx_data), .adc_data(adc_data),
        .play_data(play_data), .rec_data(rec_data), .play_slot(play_slot),
        .rec_slot(rec_slot), .core_tick(core_tick), .fs_tick(fs_tick),
        .filt_sel(filt_sel), .pll_on(pll_on), .pll_integer_ratio(pll_integer_ratio),
        .pll_fraction_ratio(pll_fraction_ratio));
    acg_host_model u_host (.host_en(host_en), .mclk(mclk), .bclk(hbclk), .frame(hframe),
        .data(play_pin));

    // 50 ns system clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // event counters; rates are judged from counts, not from edge timing
    always @(posedge mclk) n_mclk <= n_mclk + 1;
    always @(posedge sys_clk) begin
        n_core <= n_core + core_tick;
        bclk_q <= bclk_pin.o;
        n_bclk <= n_bclk + (bclk_pin.o & ~bclk_q);
        if (fs_tick) begin
            gap <= run + core_tick;
            run <= 0;
        end else begin
            run <= run + core_tick;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // async reference gives a count slack of a few ticks
    function automatic logic [31:0] near(input int s, input int e, input int t);
        return (s - e <= t && e - s <= t) ? e : s;
    endfunction
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // one-cycle register strobes, changed just after the edge
    task automatic wr(input logic [7:0] a, input logic [8:0] d);
        @(posedge sys_clk);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [8:0] d);
        @(posedge sys_clk);
        bus <= '{1'b0, 1'b1, a, 9'h000};
        @(posedge sys_clk);
        bus <= '0;
        #1 d = rdata;
    endtask
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic span(input int w, output int c, output int b, output int m);
        int c0, b0, m0;
        @(posedge sys_clk);
        #1;
        c0 = n_core;
        b0 = n_bclk;
        m0 = n_mclk;
        repeat (w) @(posedge sys_clk);
        #1;
        c = n_core - c0;
        b = n_bclk - b0;
        m = n_mclk - m0;
    endtask
    task automatic wait_tog(input logic which);
        logic p;
        int k;
        p = which ? frame_in : frame_pin.o;
        for (k = 0; k < 3000 && (which ? frame_in : frame_pin.o) === p; k++) @(posedge sys_clk);
        check(k < 3000, 1);
        #1;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // hang guard, well past the expected run length
    initial begin
        #4_000_000;
        check(0, 1);
        end_of_test();
    end

    initial begin
        logic [8:0] d;
        logic [8:0] v [9];
        int c, b, m, e, i, wl, fm, by;
        logic [31:0] w;
        reset_n = 1'b0;
        host_en = 1'b0;
        bus = '0;
        rec_tx_data = 1'b0;
        play_tx_data = 1'b0;
        adc_data = 1'b0;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        // pll is the default source but stays off, so no core clock
        span(200, c, b, m);
        check(c, 0);
        for (i = 0; i < 9; i++) begin
            rd({ACG_REG_IDX[i], 2'b00}, d);
            check(d, ACG_REG_RST[i]);
        end
        check(pll_integer_ratio, 4'hc);
        check(pll_fraction_ratio, 24'h31_26e9);
        // random readback; the integer register is rewritten with its reset value to keep its range
        for (i = 0; i < 9; i++) begin
            w = rnd();
            v[i] = (i == 5) ? 9'h04c : w[8:0];
            wr({ACG_REG_IDX[i], 2'b00}, v[i]);
            rd({ACG_REG_IDX[i], 2'b00}, d);
            check(d, v[i]);
        end
        settle();
        check(pll_fraction_ratio, {v[6][5:0], v[7], v[8]});
        wr(8'h08, 9'h1ff);
        rd(8'h08, d);
        check(d, 0);
        for (i = 0; i < 8; i++) begin
            wr(8'h1c, 9'(i << 1));
            settle();
            check(filt_sel, (i > 5) ? 5 : i);
        end
        for (i = 0; i < 16; i++) begin
            wr(8'h04, {3'b000, i[2], 3'b000, i[1:0]});
            wr(8'h90, {1'b0, i[3], 3'b001, 4'h8});
            settle();
            check(pll_on, i[2] && i[1:0] != 0 && !i[3]);
        end
        $display("test registers done");
        for (i = 0; i < 8; i++) begin
            wr(8'h18, {1'b0, i[2:0], 5'h00});
            span(600, c, b, m);
            e = m * 2 / div2[i];
            check(near(c, e, 2), e);
        end
        for (i = 0; i < 8; i++) begin
            wr(8'h18, {4'h0, i[2:0], 2'b01});
            settle();
            check(bclk_pin.oe & frame_pin.oe, 1);
            span(1600, c, b, m);
            e = c / (2 << ((i > 5) ? 5 : i));
            check(near(b, e, 1), e);
        end
        wr(8'h18, 9'h001);
        for (i = 0; i < 6; i++) begin
            wl = (i < 4) ? i : ((i == 4) ? 3 : 2);
            fm = (i == 4) ? 0 : 1;
            by = (i == 5);
            wr(8'h10, {2'b00, wl[1:0], fm[1:0], 3'b000});
            wr(8'h14, {3'b000, by[0], 5'h00});
            wait_tog(0);
            wait_tog(0);
            b = n_bclk;
            wait_tog(0);
            e = by ? 8 : ((fm == 0 && wl == 3) ? 24 : wlb[wl]);
            check(n_bclk - b, e);
        end
        span(3400, c, b, m);
        check(gap, 256);
        $display("test master clocks done");
        for (i = 6; i < 9; i++) wr({ACG_REG_IDX[i], 2'b00}, 9'h000);
        wr(8'h04, 9'h021);
        wr(8'h18, 9'h100);
        for (i = 0; i < 4; i++) begin
            wr(8'h90, {3'b000, i[1:0], 4'h8});
            span(400, c, b, m);
            e = (m * 4) >> i;
            check(near(c, e, 2), e);
        end
        wr(8'h94, 9'h020);
        wr(8'h90, 9'h055);
        span(640, c, b, m);
        e = m * 11 / 8;
        check(near(c, e, 3), e);
        // fraction left nonzero on purpose to show it is ignored
        wr(8'h90, 9'h015);
        span(640, c, b, m);
        e = m * 5 / 4;
        check(near(c, e, 3), e);
        // status word: rec and play slot high, phase low, pll source, pll running
        rd(8'ha0, d);
        check(d, 9'h01b);
        $display("test pll done");
        wr(8'h18, 9'h000);
        host_en <= 1'b1;
        settle();
        check({bclk_pin.oe, frame_pin.oe, bclk_pin.o, frame_pin.o}, 0);
        for (i = 0; i < 4; i++) begin
            wr(8'h10, {6'b000000, i[1], i[0], 1'b0});
            wait_tog(1);
            repeat (6) @(posedge sys_clk);
            #1;
            check(play_slot, frame_in == i[1]);
            check(rec_slot, frame_in == i[0]);
        end
        for (i = 0; i < 8; i++) begin
            w = rnd();
            wr(8'h14, {2'b00, i[2], 5'h00, 1'b1});
            @(posedge sys_clk);
            rec_tx_data <= w[0];
            play_tx_data <= w[1];
            adc_data <= w[2];
            repeat (2) @(posedge sys_clk);
            #1;
            check(play_data, w[0]);
            check(rec_data, i[2] ? w[1] : w[2]);
        end
        $display("test slave and loopback done");
        end_of_test();
    end
endmodule
